// *** hw/rsp_pkg.sv ***
// constants and types for the reset, sleep and power control block
// Summary of operation
// - converter stays powered in sleep if enabled
// - re-enabled converter does extended conversion next
// - comparator off in deep sleep modes
// - comparator reference use keeps reference on
// - brown-out detector on in sleep if fused
// - reference on only when a user needs it
// - enabled watchdog keeps running in sleep
// - input buffers gated in deep sleep, wake kept
// - debug fuse keeps main clock in deep sleep while test port on
// - data out undriven unless test port shifting
// - reset loads registers, then fetch from vector
// - port reset immediate for supply and pin sources, needs no clock
// - delay counter stretches reset after release
// - exactly five reset sources combined
// - power-on request while supply below threshold
// - pin request after minimum low pulse
// - watchdog request on enabled timeout
// - brown-out request only when detector enabled
// - test-port request while its register is one
// - watchdog pulse one cycle, count after fall
// - one sticky flag per source, write zero clears
// - power-on clears other flags, not itself
package rsp_pkg;
  localparam int         DW = 8;
  localparam int         AW = 2;
  localparam logic [1:0] ADDR_STAT  = 2'h0;
  localparam logic [1:0] ADDR_CTRL  = 2'h1;
  localparam logic [1:0] ADDR_STATE = 2'h2;
  // status register fields
  localparam int         NSRC      = 5;
  localparam int         BIT_POR   = 0;
  localparam int         BIT_PIN   = 1;
  localparam int         BIT_BOD   = 2;
  localparam int         BIT_WDT   = 3;
  localparam int         BIT_TP    = 4;
  localparam int         BIT_TPDIS = 7;
  localparam logic [7:0] STAT_RST  = 8'h01;
  // control register fields
  localparam int         BIT_CONV  = 0;
  localparam int         BIT_CMPOFF = 1;
  localparam int         BIT_CMPREF = 2;
  localparam int         SM_LO     = 4;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  // sleep mode encodings
  localparam logic [2:0] SM_IDLE   = 3'h0;
  localparam logic [2:0] SM_NOISE  = 3'h1;
  localparam logic [2:0] SM_PDOWN  = 3'h2;
  localparam logic [2:0] SM_PSAVE  = 3'h3;
  // pin pulse filter timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXT_MIN_NS    = 1500;
  localparam int EXT_MIN_CYC   =
    (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW            = 9;
  localparam int CW            = 24;
  typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} rsp_state_t;
endpackage : rsp_pkg

// *** hw/rsp_ctrl.sv ***
// reset combining, stretching and sleep power gating
//
// Design decisions made here: the strobed register port and the placing of the registers.
module rsp_ctrl #(
  parameter logic [23:0] TOUT0 = 24'h000006,
  parameter logic [23:0] TOUT1 = 24'h001000,
  parameter logic [23:0] TOUT2 = 24'h00fa00,
  parameter logic [23:0] TOUT3 = 24'h0fa000
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // supply monitors and reset pin, asynchronous
  input  wire logic       porBelow,
  input  wire logic       rstPin_b,
  input  wire logic       bodBelow,
  // same-clock sources
  input  wire logic       wdtTimeout,
  input  wire logic       wdtEnable,
  input  wire logic       testPortResetReg,
  // static fuses
  input  wire logic       brownoutEnableFuse,
  input  wire logic       testPortEnableFuse,
  input  wire logic       onchipDebugEnableFuse,
  input  wire logic [1:0] clockSelectFuses,
  // sleep and converter status
  input  wire logic       sleepActive,
  input  wire logic       convStart,
  // test access port
  input  wire logic       tapShifting,
  input  wire logic       tapTdo,
  // register port
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // outputs
  output logic            portReset,
  output logic            sysReset,
  output logic            cpuStart,
  output logic            convPowered,
  output logic            convExtended,
  output logic            compEnable,
  output logic            refEnable,
  output logic            bodActive,
  output logic            wdtRun,
  output logic            inBufEnable,
  output logic            wakeBufEnable,
  output logic            mainClkKeep,
  output logic            testPortEnable,
  output logic            tdoOut,
  output logic            tdoOe
);

  // async pin inputs: por, pin, bod
  localparam int NS = 3;
  logic [NS-1:0] syncRaw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  assign syncRaw = {bodBelow, ~rstPin_b, porBelow};

  // two-flop synchroniser per pin
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= syncRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic porS;
  logic pinLowS;
  logic bodS;
  assign porS    = sync2_q[0];
  assign pinLowS = sync2_q[1];
  assign bodS    = sync2_q[2];

  // pin low-time filter, saturating
  logic [rsp_pkg::PW-1:0] lowCnt_q;
  localparam logic [rsp_pkg::PW-1:0] EXT_MIN =
    rsp_pkg::PW'(rsp_pkg::EXT_MIN_CYC);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lowCnt_q <= '0;
    end else if (!pinLowS) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q != EXT_MIN) begin
      lowCnt_q <= lowCnt_q + 1'b1;
    end
  end

  // the five reset requests
  logic [rsp_pkg::NSRC-1:0] req;
  logic                     anyReq;
  always_comb begin
    req = '0;
    req[rsp_pkg::BIT_POR] = porS;
    req[rsp_pkg::BIT_PIN] = (lowCnt_q == EXT_MIN);
    req[rsp_pkg::BIT_BOD] = bodS & brownoutEnableFuse;
    req[rsp_pkg::BIT_WDT] = wdtTimeout & wdtEnable;
    req[rsp_pkg::BIT_TP]  = testPortResetReg;
  end
  assign anyReq = |req;

  // delay terminal from the clock-select fuses
  logic [rsp_pkg::CW-1:0] term;
  always_comb begin
    case (clockSelectFuses)
      2'h0:    term = TOUT0;
      2'h1:    term = TOUT1;
      2'h2:    term = TOUT2;
      default: term = TOUT3;
    endcase
  end

  // reset sequencer
  rsp_pkg::rsp_state_t    st_q;
  rsp_pkg::rsp_state_t    st_d;
  logic [rsp_pkg::CW-1:0] cnt_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      rsp_pkg::ST_HOLD:
        if (!anyReq) st_d = rsp_pkg::ST_STRETCH;
      rsp_pkg::ST_STRETCH:
        if (anyReq) st_d = rsp_pkg::ST_HOLD;
        else if (cnt_q >= term - 1'b1) st_d = rsp_pkg::ST_RUN;
      rsp_pkg::ST_RUN:
        if (anyReq) st_d = rsp_pkg::ST_HOLD;
      default: st_d = rsp_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= rsp_pkg::ST_HOLD;
    end else begin
      st_q <= st_d;
    end
  end

  // delay counter, cleared while any request stands
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (st_q != rsp_pkg::ST_STRETCH || anyReq) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // internal reset and start pulse toward the core
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sysReset <= 1'b1;
      cpuStart <= 1'b0;
    end else begin
      sysReset <= (st_d != rsp_pkg::ST_RUN);
      cpuStart <= (st_d == rsp_pkg::ST_RUN) && (st_q != rsp_pkg::ST_RUN);
    end
  end

  // port reset: raw sources bypass the flops so it works
  // with the clock stopped; the only unregistered output
  logic portRstQ;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      portRstQ <= 1'b1;
    end else begin
      portRstQ <= sysReset;
    end
  end
  assign portReset = porBelow | ~rstPin_b | (bodBelow & brownoutEnableFuse)
                   | portRstQ;

  // software control register
  logic [7:0] ctrl_q;
  logic [2:0] sleepMode;
  always_ff @(posedge core_clk) begin
    if (!rst_b || sysReset) begin
      ctrl_q <= rsp_pkg::CTRL_RST;
    end else if (regWr && regAddr == rsp_pkg::ADDR_CTRL) begin
      ctrl_q <= regWdata;
    end
  end
  assign sleepMode = ctrl_q[rsp_pkg::SM_LO+:3];

  // sticky reset flags; a set beats a same-cycle clear
  logic [4:0] flag_q;
  logic       tpDis_q;
  logic       statWr;
  logic [4:0] keep;
  assign statWr = regWr && regAddr == rsp_pkg::ADDR_STAT;
  assign keep = statWr ? regWdata[4:0] : 5'h1f;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flag_q <= rsp_pkg::STAT_RST[4:0];
    end else if (porS) begin
      flag_q <= 5'h01;
    end else begin
      flag_q <= req | (flag_q & keep);
    end
  end

  // test-port disable bit
  always_ff @(posedge core_clk) begin
    if (!rst_b || sysReset) begin
      tpDis_q <= rsp_pkg::STAT_RST[rsp_pkg::BIT_TPDIS];
    end else if (statWr) begin
      tpDis_q <= regWdata[rsp_pkg::BIT_TPDIS];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b || !regRd) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        rsp_pkg::ADDR_STAT:  regRdata <= {tpDis_q, 2'h0, flag_q};
        rsp_pkg::ADDR_CTRL:  regRdata <= ctrl_q;
        rsp_pkg::ADDR_STATE: regRdata <= {3'h0, convExtended,
                                          testPortEnable, inBufEnable,
                                          refEnable, sysReset};
        default:             regRdata <= 8'h00; // unmapped
      endcase
    end
  end

  // sleep classification
  logic deepSleep;
  logic pdSleep;
  logic convOn;
  logic cmpUser;
  assign convOn  = ctrl_q[rsp_pkg::BIT_CONV];
  assign cmpUser = ~ctrl_q[rsp_pkg::BIT_CMPOFF];
  // io and converter clocks both stop in all but idle and noise
  assign deepSleep = sleepActive && sleepMode != rsp_pkg::SM_IDLE
                     && sleepMode != rsp_pkg::SM_NOISE;
  assign pdSleep = sleepActive && (sleepMode == rsp_pkg::SM_PDOWN
                   || sleepMode == rsp_pkg::SM_PSAVE);

  // converter power and extended-conversion marker
  logic convOnPrev;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      convOnPrev   <= 1'b0;
      convPowered  <= 1'b0;
      convExtended <= 1'b1;
    end else begin
      convOnPrev  <= convOn;
      convPowered <= convOn;
      if (convOn && !convOnPrev) begin
        convExtended <= 1'b1;
      end else if (convStart && convPowered) begin
        convExtended <= 1'b0;
      end
    end
  end

  // analog enables; reference stays on for comparator use
  // even in sleep, which is why software should drop it first
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      compEnable <= 1'b0;
      refEnable  <= 1'b0;
      bodActive  <= 1'b0;
      wdtRun     <= 1'b0;
    end else begin
      compEnable <= cmpUser && !deepSleep;
      refEnable  <= brownoutEnableFuse || convOn
                    || (cmpUser && ctrl_q[rsp_pkg::BIT_CMPREF]);
      bodActive  <= brownoutEnableFuse;
      wdtRun     <= wdtEnable;
    end
  end

  // input buffers and main clock keep-alive
  logic tpOn;
  assign tpOn = testPortEnableFuse && !tpDis_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      inBufEnable    <= 1'b1;
      wakeBufEnable  <= 1'b1;
      mainClkKeep    <= 1'b1;
      testPortEnable <= 1'b0;
    end else begin
      inBufEnable    <= !deepSleep;
      wakeBufEnable  <= 1'b1;
      mainClkKeep    <= !pdSleep || (onchipDebugEnableFuse && tpOn);
      testPortEnable <= tpOn;
    end
  end

  // serial data out, released when not shifting
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tdoOut <= 1'b0;
      tdoOe  <= 1'b0;
    end else begin
      tdoOut <= tapTdo;
      tdoOe  <= tpOn && tapShifting;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  run_needs_quiet_a: assert property (
    anyReq |=> sysReset)
    else $error("reset request did not hold reset");
  stretch_len_a: assert property (
    $rose(st_q == rsp_pkg::ST_STRETCH) && !anyReq
    && term == 24'h6 ##1 !anyReq [*5] |=> !sysReset)
    else $error("reset stretch length wrong");
  restart_cnt_a: assert property (
    anyReq |=> cnt_q == '0)
    else $error("delay count not restarted");
  pin_filter_a: assert property (
    req[rsp_pkg::BIT_PIN] |-> $past(pinLowS, 2))
    else $error("pin request without low pulse");
  flag_set_a: assert property (
    req[rsp_pkg::BIT_WDT] && !porS |=> flag_q[rsp_pkg::BIT_WDT])
    else $error("watchdog flag lost");
  por_clear_a: assert property (
    porS |=> flag_q == 5'h01)
    else $error("power-on flag handling wrong");
  comp_sleep_a: assert property (
    deepSleep |=> !compEnable)
    else $error("comparator on in deep sleep");
  ref_need_a: assert property (
    !brownoutEnableFuse && !convOn && !ctrl_q[rsp_pkg::BIT_CMPREF]
    |=> !refEnable)
    else $error("reference on without user");
  buf_gate_a: assert property (
    sleepActive && sleepMode == rsp_pkg::SM_PDOWN |=> !inBufEnable)
    else $error("input buffers on in power-down");
  tdo_float_a: assert property (
    !tapShifting |=> !tdoOe)
    else $error("data out driven while idle");
  ext_conv_a: assert property (
    $rose(convOn) |=> convExtended)
    else $error("extended conversion not marked");

  wdt_reset_c: cover property (
    req[rsp_pkg::BIT_WDT] ##1 !anyReq [*3]);
  full_start_c: cover property (
    $fell(sysReset) && cpuStart);
  debug_clk_c: cover property (
    pdSleep && mainClkKeep);

endmodule : rsp_ctrl

// *** bench/rsp_partner.sv ***
// far-side model: watchdog timer and test access port
module rsp_partner #(
  parameter int PERIOD = 10
) (
  input  wire logic core_clk,
  input  wire logic wdtEnable,
  input  wire logic wdtArm,
  input  wire logic tapShiftReq,
  output logic      wdtTimeout = 1'b0,
  output logic      tapShifting = 1'b0,
  output logic      tapTdo = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int wdtCnt_q = 0;
  // watchdog expiry, one cycle wide, only while armed and enabled
  always @(posedge core_clk) begin
    wdtTimeout <= 1'b0;
    if (wdtEnable && wdtArm) begin
      wdtCnt_q   <= (wdtCnt_q == PERIOD - 1) ? 0 : wdtCnt_q + 1;
      wdtTimeout <= (wdtCnt_q == PERIOD - 1);
    end else begin
      wdtCnt_q <= 0;
    end
  end
  // data toggles every cycle so a stale copy downstream shows up
  always @(posedge core_clk) begin
    tapShifting <= tapShiftReq;
    tapTdo      <= ~tapTdo;
  end
endmodule : rsp_partner

// *** bench/rsp_ctrl_tb.sv ***
// self-checking bench for the reset, sleep and power control block
`define CHK(got, exp) begin \
  cmpCount++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module rsp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         TERM = 6;
  localparam logic [2:0] MODES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic       core_clk, rst_b, porBelow, rstPin_b, bodBelow, wdtEnable, wdtArm;
  logic       tpRstReg, bodFuse, tpFuse, dbgFuse, sleepActive, convStart;
  logic       tapShiftReq, tapShifting, tapTdo, wdtTimeout, regWr, regRd;
  logic [1:0] regAddr, clock_select_fuses;
  logic [7:0] regWdata, regRdata;
  logic       portReset, sysReset, cpuStart, convPowered, convExtended, compEnable;
  logic       refEnable, bodActive, wdtRun, inBufEnable, wakeBufEnable, mainClkKeep;
  logic       testPortEnable, tdoOut, tdoOe;
  int         errorCnt = 0;
  int         cmpCount = 0;

  rsp_ctrl #(.TOUT0(24'h000006), .TOUT1(24'h000014)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .porBelow(porBelow), .rstPin_b(rstPin_b), .bodBelow(bodBelow),
    .wdtTimeout(wdtTimeout), .wdtEnable(wdtEnable), .testPortResetReg(tpRstReg),
    .brownoutEnableFuse(bodFuse), .testPortEnableFuse(tpFuse),
    .onchipDebugEnableFuse(dbgFuse), .clockSelectFuses(clock_select_fuses),
    .sleepActive(sleepActive), .convStart(convStart), .tapShifting(tapShifting),
    .tapTdo(tapTdo), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .portReset(portReset), .sysReset(sysReset),
    .cpuStart(cpuStart), .convPowered(convPowered), .convExtended(convExtended),
    .compEnable(compEnable), .refEnable(refEnable), .bodActive(bodActive),
    .wdtRun(wdtRun), .inBufEnable(inBufEnable), .wakeBufEnable(wakeBufEnable),
    .mainClkKeep(mainClkKeep), .testPortEnable(testPortEnable), .tdoOut(tdoOut),
    .tdoOe(tdoOe));
  rsp_partner farSide (.core_clk(core_clk), .wdtEnable(wdtEnable), .wdtArm(wdtArm),
    .tapShiftReq(tapShiftReq), .wdtTimeout(wdtTimeout), .tapShifting(tapShifting),
    .tapTdo(tapTdo));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask : rd

  // bounded wait for the internal reset to reach v, span checked
  task automatic waitLevel(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (sysReset !== v && n < 600) begin
      settle(1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    if (v == 1'b0) begin
      `CHK(cpuStart, 1'b1)
      settle(1);
      `CHK(cpuStart, 1'b0)
    end
  endtask : waitLevel

  task automatic summarize();
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // hang guard, well beyond the several hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge core_clk);
    errorCnt++;
    summarize();
  end

  // main sequence
  initial begin
    {rst_b, porBelow, bodBelow, wdtEnable, wdtArm, tpRstReg, bodFuse} = '0;
    {dbgFuse, sleepActive, convStart, tapShiftReq, regWr, regRd} = '0;
    {regAddr, regWdata, clock_select_fuses} = '0;
    rstPin_b = 1'b1;
    tpFuse   = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    waitLevel(1'b0, 3, 14);
    rd(2'h0, 8'h01);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    // watchdog expiry
    wdtEnable <= 1'b1;
    wdtArm    <= 1'b1;
    waitLevel(1'b1, 1, 14);
    wdtArm <= 1'b0;
    waitLevel(1'b0, TERM, TERM + 3);
    rd(2'h0, 8'h08);
    // brown-out refused without the fuse, then taken
    bodBelow <= 1'b1;
    settle(20);
    `CHK({sysReset, portReset}, 2'b00)
    bodFuse <= 1'b1;
    #1;
    `CHK(portReset, 1'b1)
    waitLevel(1'b1, 0, 6);
    bodBelow <= 1'b0;
    waitLevel(1'b0, TERM, TERM + 5);
    rd(2'h0, 8'h0c);
    wr(2'h0, 8'h00);
    bodFuse <= 1'b0;
    // pin held low: port reset at once but no internal reset after 100 cycles, then the same low pulse accepted
    rstPin_b <= 1'b0;
    settle(100);
    `CHK({sysReset, portReset}, 2'b01)
    waitLevel(1'b1, 250, 300);
    rstPin_b <= 1'b1;
    waitLevel(1'b0, TERM, TERM + 5);
    rd(2'h0, 8'h02);
    // test-port request holds reset; a repeat mid-stretch restarts the count
    tpRstReg <= 1'b1;
    waitLevel(1'b1, 0, 3);
    settle(30);
    `CHK(sysReset, 1'b1)
    tpRstReg <= 1'b0;
    settle(3);
    tpRstReg <= 1'b1;
    settle(1);
    tpRstReg <= 1'b0;
    waitLevel(1'b0, TERM, TERM + 3);
    rd(2'h0, 8'h12);
    porBelow <= 1'b1;
    settle(4);
    `CHK(sysReset, 1'b1)
    porBelow <= 1'b0;
    waitLevel(1'b0, TERM, TERM + 5);
    rd(2'h0, 8'h01);
    // extended conversion after a power cycle of the converter
    wr(2'h1, 8'h01);
    // let the converter power up before the first start is counted
    settle(2);
    convStart <= 1'b1;
    @(posedge core_clk);
    convStart <= 1'b0;
    settle(2);
    `CHK(convExtended, 1'b0)
    wr(2'h1, 8'h00);
    wr(2'h1, 8'h01);
    settle(2);
    `CHK(convExtended, 1'b1)
    // sleep modes 0-3, 6 and 7 with the converter enabled
    sleepActive <= 1'b1;
    foreach (MODES[i]) begin
      wr(2'h1, {1'b0, MODES[i], 4'h1});
      settle(3);
      `CHK({compEnable, inBufEnable}, {2{MODES[i] < 3'h2}})
      `CHK({wakeBufEnable, convPowered, refEnable, wdtRun}, 4'hf)
      `CHK(mainClkKeep, !(MODES[i] == 3'h2 || MODES[i] == 3'h3))
    end
    dbgFuse <= 1'b1;
    wr(2'h1, 8'h21);
    settle(3);
    `CHK(mainClkKeep, 1'b1)
    // reference only when some user needs it
    wr(2'h1, 8'h22);
    settle(3);
    `CHK({refEnable, bodActive}, 2'b00)
    wr(2'h1, 8'h24);
    settle(3);
    `CHK(refEnable, 1'b1)
    wr(2'h1, 8'h22);
    bodFuse <= 1'b1;
    settle(3);
    `CHK({refEnable, bodActive}, 2'b11)
    // test port disable bit and fuse, data out release
    tapShiftReq <= 1'b1;
    wr(2'h0, 8'h81);
    rd(2'h0, 8'h81);
    settle(2);
    `CHK({testPortEnable, tdoOe}, 2'b00)
    wr(2'h0, 8'h01);
    settle(3);
    `CHK({testPortEnable, tdoOe, tdoOut}, {2'b11, ~tapTdo})
    tapShiftReq <= 1'b0;
    settle(3);
    `CHK(tdoOe, 1'b0)
    tpFuse <= 1'b0;
    settle(3);
    `CHK(testPortEnable, 1'b0)
    // second fuse setting selects the longer stretch
    clock_select_fuses    <= 2'h1;
    tpRstReg <= 1'b1;
    settle(2);
    tpRstReg <= 1'b0;
    waitLevel(1'b0, 20, 23);
    rd(2'h0, 8'h11);
    summarize();
  end
endmodule : rsp_ctrl_tb
